// ---- hw/amp_i2c_port.sv ----
// two-wire slave port: control byte writes and diagnostic byte reads
`timescale 1ns/10ps
`default_nettype none
module amp_i2c_port
  import amp_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // serial bus pins, data line open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // address_select_pin, decoded to a code
  input wire logic [1:0] address_select_pin_in,
  // live diagnostic results of the last finished cycle
  input wire amp_diag1_s first_diag_byte_in,
  input wire logic [7:0] second_diag_byte_in,
  input wire logic [7:0] third_diag_byte_in,
  input wire logic [7:0] fourth_diag_byte_in,
  // control bytes toward the amplifier
  output amp_primary_s primary_control_byte_out,
  output amp_secondary_s secondary_control_byte_out,
  // one-cycle request to start a new diagnostic cycle
  output logic diag_restart_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic scl_meta_r;         // first synchroniser stage, clock
  logic scl_sync_r;         // second stage
  logic scl_prev_r;         // one cycle older, for edges
  logic sda_meta_r;         // first synchroniser stage, data
  logic sda_sync_r;         // second stage
  logic sda_prev_r;         // one cycle older, for edges
  logic [1:0] adsel_meta_r; // select pin, first stage
  logic [1:0] adsel_sync_r; // select pin, second stage
  logic scl_rise;           // clock rising edge seen
  logic scl_fall;           // clock falling edge seen
  logic bus_start;          // start condition seen
  logic bus_stop;           // stop condition seen
  logic bus_en;             // select pin not left open
  logic [6:0] own_addr;     // address picked by the pin
  amp_state_e state_r;      // protocol state
  amp_state_e state_nxt;
  logic [3:0] bit_cnt_r;    // bits taken in the current byte
  logic [7:0] shift_r;      // incoming byte, msb first
  logic [7:0] tx_r;         // outgoing byte, msb first
  logic rw_r;               // direction of the current transfer
  logic [2:0] wr_idx_r;     // control bytes received
  logic [2:0] rd_idx_r;     // diagnostic bytes sent
  logic master_ack_r;       // master pulled the line in its ack slot
  logic read_active_r;      // a read was addressed to us
  logic sda_oe_r;           // pulling the data line low
  logic sda_oe_nxt;
  logic diag_restart_r;     // restart pulse
  logic byte_done;          // falling edge after eight bits
  logic addr_hit;           // our address, at the end of the address byte
  logic snap;               // capture diagnostics for this read
  logic rd_more;            // master wants another byte and one is left
  logic [7:0] rd_data;      // diagnostic byte out of the store
  amp_primary_s primary_r;
  amp_secondary_s secondary_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  // two synchroniser flops per pin plus one for edges; idle bus lines read high from reset on
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  // the select pin is static, but still crosses in like any pin
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      adsel_meta_r <= ADSEL_OPEN;
      adsel_sync_r <= ADSEL_OPEN;
    end else begin
      adsel_meta_r <= address_select_pin_in;
      adsel_sync_r <= adsel_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------

  // data is only sampled on clock edges, so changes during low are harmless
  assign scl_rise = scl_sync_r & ~scl_prev_r;
  assign scl_fall = ~scl_sync_r & scl_prev_r;
  // data edges with clock steady high mark frame boundaries
  assign bus_start = scl_sync_r & scl_prev_r & ~sda_sync_r & sda_prev_r;
  assign bus_stop = scl_sync_r & scl_prev_r & sda_sync_r & ~sda_prev_r;

  // eight data bits counted before the ack slot
  assign byte_done = scl_fall && (bit_cnt_r == BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // pin code to bus address; open pin leaves the port deaf
  always_comb begin
    own_addr = BUS_ADDR_LOW;
    if (adsel_sync_r == ADSEL_MID) begin
      own_addr = BUS_ADDR_MID;
    end else if (adsel_sync_r == ADSEL_HIGH) begin
      own_addr = BUS_ADDR_HIGH;
    end
  end
  assign bus_en = (adsel_sync_r != ADSEL_OPEN);

  // only a full match is acked; anything else is silently ignored
  assign addr_hit = (state_r == ST_ADDR) && byte_done && bus_en
                    && (shift_r[7:1] == own_addr);
  // a read addressed to us freezes the last cycle's results
  assign snap = addr_hit && shift_r[RW_BIT];
  // another byte only if the master acked and bytes remain
  assign rd_more = master_ack_r && (rd_idx_r < DIAG_COUNT);

  // ----------------------------------------------------------------
  // protocol state machine
  // ----------------------------------------------------------------

  // next state; start and stop win over any bit in progress
  always_comb begin
    state_nxt = state_r;
    if (bus_start) begin
      state_nxt = ST_ADDR;
    end else if (bus_stop) begin
      state_nxt = ST_IDLE;
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: begin
          if (byte_done) begin
            state_nxt = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK: begin
          state_nxt = rw_r ? ST_RD_BYTE : ST_WR_BYTE;
        end
        ST_WR_BYTE: begin
          if (byte_done) begin
            state_nxt = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          // two control bytes, then further bytes go unacked
          state_nxt = (wr_idx_r < CTRL_COUNT) ? ST_WR_BYTE : ST_IGNORE;
        end
        ST_RD_BYTE: begin
          if (byte_done) begin
            state_nxt = ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          state_nxt = rd_more ? ST_RD_BYTE : ST_IGNORE;
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bit counter: counts rising edges inside a byte, cleared around acks
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bit_cnt_r <= 4'h0;
    end else if (bus_start || bus_stop) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_WR_ACK
                              || state_r == ST_RD_ACK)) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && (state_r == ST_ADDR || state_r == ST_WR_BYTE
                              || state_r == ST_RD_BYTE)) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------

  // shift in on the rising edge, msb first
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      shift_r <= 8'h00;
    end else if (scl_rise && (state_r == ST_ADDR || state_r == ST_WR_BYTE)) begin
      shift_r <= {shift_r[6:0], sda_sync_r};
    end
  end

  // direction latched from bit 0 of the address byte
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rw_r <= 1'b0;
    end else if (addr_hit) begin
      rw_r <= shift_r[RW_BIT];
    end
  end

  // control byte index: first primary, then secondary
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_idx_r <= 3'h0;
    end else if (bus_start) begin
      wr_idx_r <= 3'h0;
    end else if (byte_done && state_r == ST_WR_BYTE) begin
      wr_idx_r <= wr_idx_r + 3'h1;
    end
  end

  // control registers; a partial write keeps the byte not yet sent
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      primary_r <= amp_primary_s'(CTRL_RESET);
      secondary_r <= amp_secondary_s'(CTRL_RESET);
    end else if (byte_done && state_r == ST_WR_BYTE) begin
      if (wr_idx_r == 3'h0) begin
        primary_r <= amp_primary_s'(shift_r);
      end else if (wr_idx_r == 3'h1) begin
        // the two spare bits never reach the amplifier
        secondary_r <= amp_secondary_s'(shift_r & SECONDARY_MASK);
      end
    end
  end

  // fields land on the amplifier controls by the struct layout
  assign primary_control_byte_out = primary_r;
  assign secondary_control_byte_out = secondary_r;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------

  // the store holds the bytes of the previous cycle for this whole read
  amp_diag_store #(
    .WIDTH(BYTE_W),
    .DEPTH(DIAG_BYTES)
  ) u_store (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(snap),
    .data_in({fourth_diag_byte_in, third_diag_byte_in, second_diag_byte_in,
              first_diag_byte_in}),
    .rd_addr_in(rd_idx_r[1:0]),
    .rd_data_out(rd_data)
  );

  // read index: bumped as each byte ends, so the store has a whole
  // serial clock period, the ack slot, to present the next byte before it is needed
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_idx_r <= 3'h0;
    end else if (snap) begin
      rd_idx_r <= 3'h0;
    end else if (byte_done && state_r == ST_RD_BYTE) begin
      rd_idx_r <= rd_idx_r + 3'h1;
    end
  end

  // master ack sampled on the rising edge of its slot
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      master_ack_r <= 1'b0;
    end else if (scl_rise && state_r == ST_RD_ACK) begin
      master_ack_r <= ~sda_sync_r;
    end
  end

  // outgoing shifter, loaded when a byte begins, shifted per falling edge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_r <= 8'h00;
    end else if (scl_fall && state_r == ST_ADDR_ACK && rw_r) begin
      tx_r <= rd_data;
    end else if (scl_fall && state_r == ST_RD_ACK && rd_more) begin
      tx_r <= rd_data;
    end else if (scl_fall && state_r == ST_RD_BYTE && !byte_done) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // data line driver
  // ----------------------------------------------------------------

  // every change happens on a falling clock edge, except the release at a start or stop, which comes with the clock high
  always_comb begin
    sda_oe_nxt = sda_oe_r;
    if (bus_start || bus_stop) begin
      sda_oe_nxt = 1'b0;
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: begin
          sda_oe_nxt = addr_hit;
        end
        ST_ADDR_ACK: begin
          // read: first data bit straight after the ack slot
          sda_oe_nxt = rw_r & ~rd_data[7];
        end
        ST_WR_BYTE: begin
          sda_oe_nxt = byte_done;
        end
        ST_RD_BYTE: begin
          // release after the eighth bit so the master can ack
          sda_oe_nxt = byte_done ? 1'b0 : ~tx_r[6];
        end
        ST_RD_ACK: begin
          sda_oe_nxt = rd_more & ~rd_data[7];
        end
        default: begin
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // driver flop; the line is only ever pulled low, never driven high
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= sda_oe_nxt;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_r;

  // ----------------------------------------------------------------
  // diagnostic restart
  // ----------------------------------------------------------------

  // a read addressed to us is open until the next start or stop
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      read_active_r <= 1'b0;
    end else if (snap) begin
      read_active_r <= 1'b1;
    end else if (bus_start || bus_stop) begin
      read_active_r <= 1'b0;
    end
  end

  // new cycle requested when the read ends; the bytes already went out,
  // so the reader always sees the cycle before the one now starting
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      diag_restart_r <= 1'b0;
    end else begin
      diag_restart_r <= read_active_r & (bus_start | bus_stop);
    end
  end
  assign diag_restart_out = diag_restart_r;

endmodule // amp_i2c_port
`default_nettype wire

// ---- hw/amp_pkg.sv ----
// shared constants, types and layouts for the amplifier two-wire control port
package amp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;                       // bits per byte
  localparam int DIAG_BYTES = 4;                   // bytes returned by a read
  localparam int CTRL_BYTES = 2;                   // bytes taken by a write
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;     // data bits before the ack slot
  localparam logic [2:0] CTRL_COUNT = 3'h2;        // CTRL_BYTES at counter width
  localparam logic [2:0] DIAG_COUNT = 3'h4;        // DIAG_BYTES at counter width

  // ----------------------------------------------------------------
  // timing: serial clock period over system clock period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;               // system clock
  localparam int LINK_PERIOD_NS = 400;             // serial clock in the bench
  localparam int SAMPLES_PER_BIT = LINK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // bus addresses picked by the address select pin
  // ----------------------------------------------------------------
  localparam logic [6:0] BUS_ADDR_LOW = 7'h6c;     // pin to ground
  localparam logic [6:0] BUS_ADDR_MID = 7'h6d;     // middle resistor
  localparam logic [6:0] BUS_ADDR_HIGH = 7'h6e;    // high resistor
  localparam logic [1:0] ADSEL_LOW = 2'h0;
  localparam logic [1:0] ADSEL_MID = 2'h1;
  localparam logic [1:0] ADSEL_HIGH = 2'h2;
  localparam logic [1:0] ADSEL_OPEN = 2'h3;        // bus disabled

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int RW_BIT = 0;                       // direction bit in address byte
  localparam logic [7:0] SECONDARY_MASK = 8'hbd;   // bits 6 and 1 stored as zero
  localparam logic [7:0] CTRL_RESET = 8'h00;       // muted, standby, all defeated

  // primary control byte, bit 7 down to bit 0
  typedef struct packed {
    logic mute_thr_high;    // supply transition mute threshold high
    logic diag_en;          // diagnostics enable
    logic offset_en;        // offset detection enable
    logic front_gain_16db;  // front pair 16 dB, else 30 dB
    logic rear_gain_16db;   // rear pair 16 dB, else 30 dB
    logic front_unmute;     // front channels play
    logic rear_unmute;      // rear channels play
    logic clip_detect_10;   // clip_detect at 10 %, else 2 %
  } amp_primary_s;

  // secondary control byte, bit 7 down to bit 0
  typedef struct packed {
    logic cur_thr_low;      // low current detection threshold
    logic unused6;          // always stored as zero
    logic fast_mute;        // fast muting time
    logic run;              // out of standby
    logic line_driver_diag; // line driver diagnostic mode
    logic cur_diag_en;      // current detection diagnostic
    logic unused1;          // always stored as zero
    logic speaker_safety_routine; // start-up offset check with mute
  } amp_secondary_s;

  // first_diag_byte for channel_one (left_front), bit 7 down to bit 0
  typedef struct packed {
    logic thermal_warn1;    // first thermal warning
    logic cycle_done;       // diagnostic cycle terminated
    logic open_load;        // peak current below threshold
    logic permanent;        // permanent, else turn-on diagnostic
    logic short_load;       // shorted load
    logic open_or_offset;   // open load or output offset
    logic short_supply;     // short to positive supply
    logic short_ground;     // short to ground
  } amp_diag1_s;

  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_IGNORE
  } amp_state_e;

endpackage : amp_pkg

// ---- hw/amp_diag_store.sv ----
// snapshot store for the diagnostic bytes with registered read data
`timescale 1ns/10ps
`default_nettype none
module amp_diag_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // snapshot side: all entries loaded at once
  input wire logic load_in,
  input wire logic [WIDTH*DEPTH-1:0] data_in,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [DEPTH];  // one entry per diagnostic byte

  // every entry captured in the same cycle so a read sees one coherent cycle
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          mem_r[gi] <= '0;
        end else if (load_in) begin
          mem_r[gi] <= data_in[gi*WIDTH +: WIDTH];
        end
      end
    end
  endgenerate

  // registered read port, one cycle of latency
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule // amp_diag_store
`default_nettype wire

// ---- sim/amp_port_assertions.sv ----
// checker and bind for the amplifier two-wire port
`timescale 1ns/10ps
`default_nettype none
module amp_port_assertions
  import amp_pkg::*;
(
  // watched top ports
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [1:0] address_select_pin_in,
  input wire amp_primary_s primary_control_byte_out,
  input wire amp_secondary_s secondary_control_byte_out,
  input wire logic diag_restart_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // open drain: only ever pulls low
  AST_OD_ZERO: assert property (sda_out == 1'b0)
    else $error("data line value not low");
  // device moves data only while the serial clock is low
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 2) && !$past(scl_in, 3))
    else $error("data moved with clock high");
  // open select pin keeps the device off the bus
  AST_OPEN_SILENT: assert property ((address_select_pin_in == ADSEL_OPEN)[*4] |-> !sda_oe_out)
    else $error("drive with bus disabled");
  AST_PULSE_ONE: assert property (diag_restart_out |=> !diag_restart_out)
    else $error("restart longer than one cycle");
  // restart follows a stop or start, both with the clock high
  AST_PULSE_AT_STOP: assert property (diag_restart_out |-> $past(scl_in, 4) && $past(scl_in, 6))
    else $error("restart not after stop");
  AST_PRI_AT_FALL: assert property ($changed(primary_control_byte_out) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
    else $error("primary moved off a clock fall");
  AST_SEC_AT_FALL: assert property ($changed(secondary_control_byte_out) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
    else $error("secondary moved off a clock fall");
  AST_SEC_UNUSED: assert property ((secondary_control_byte_out & ~SECONDARY_MASK) == 8'h00)
    else $error("unused secondary bits set");
  // a pulled bit stands seven system clocks, nearly a whole serial clock period
  AST_OE_HOLD: assert property ($rose(sda_oe_out) |=> sda_oe_out [*6])
    else $error("pull released early");
  cover property (diag_restart_out);
  cover property ($rose(sda_oe_out));
  cover property ($changed(secondary_control_byte_out));
endmodule // amp_port_assertions
bind amp_i2c_port amp_port_assertions i_chk (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .address_select_pin_in(address_select_pin_in),
  .primary_control_byte_out(primary_control_byte_out),
  .secondary_control_byte_out(secondary_control_byte_out), .diag_restart_out(diag_restart_out));
`default_nettype wire

// ---- sim/amp_mcu_model.sv ----
// behavioural bus master for the serial clock and data line
`timescale 1ns/10ps
`default_nettype none
module amp_mcu_model (
  // pacing clock
  input wire logic clock_in,
  // device pull on the data line
  input wire logic dev_oe_in,
  // wire levels
  output logic scl_out,
  output logic sda_out
);
  logic drv_low; // master pulls data low
  initial begin
    drv_low = 1'b0;
    scl_out = 1'b1;
  end
  // pull-up: line is low if either party pulls
  assign sda_out = !(drv_low || dev_oe_in);
  task automatic wt(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // data moves mid low phase, away from both clock edges
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    drv_low = !b;
    wt(2);
    scl_out = 1'b1;
    wt(4);
    r = sda_out;
    scl_out = 1'b0;
  endtask
  // start (stp 0) or stop (stp 1), data toggled with clock high
  task automatic cond(input logic stp);
    wt(2);
    drv_low = stp;
    wt(2);
    scl_out = 1'b1;
    wt(4);
    drv_low = !stp;
    wt(4);
    if (!stp) begin
      scl_out = 1'b0;
    end
  endtask
  // eight bits msb first, then the ack slot; mst_ack pulls it
  task automatic xbyte(input logic [7:0] d, input logic mst_ack, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(!mst_ack, r);
    ack = !r;
  endtask
endmodule // amp_mcu_model
`default_nettype wire

// ---- sim/amp_i2c_control_status_port_bench.sv ----
// self-checking bench for the amplifier two-wire port
`timescale 1ns/10ps
`default_nettype none
module amp_i2c_control_status_port_bench;
  import amp_pkg::*;
  `define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin error_cnt++; $display("BAD %s exp %h seen %h", n, e, s); end end
  logic clock_in;
  logic rst_in;
  logic [1:0] sel; // select pin code
  amp_diag1_s dg1; // live diag results, first byte
  logic [7:0] dg2;
  logic [7:0] dg3;
  logic [7:0] dg4;
  wire scl;
  wire sdo; // open drain value from the port
  wire sda;
  wire oe;
  amp_primary_s pri;
  amp_secondary_s sec;
  logic pulse;
  int error_cnt = 0;
  int checked = 0;
  int pulses = 0;
  logic [7:0] q;
  amp_i2c_port i_dut (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
    .sda_oe_out(oe), .address_select_pin_in(sel), .first_diag_byte_in(dg1),
    .second_diag_byte_in(dg2), .third_diag_byte_in(dg3), .fourth_diag_byte_in(dg4),
    .primary_control_byte_out(pri), .secondary_control_byte_out(sec), .diag_restart_out(pulse));
  amp_mcu_model i_mcu (.clock_in(clock_in), .dev_oe_in(oe), .scl_out(scl), .sda_out(sda));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // counted on the falling edge, away from the edge that launches the pulse
  always @(negedge clock_in) if (pulse === 1'b1) pulses++;
  task automatic open_x(input logic [6:0] a, input logic rw, output logic ak);
    i_mcu.cond(1'b0);
    i_mcu.xbyte({a, rw}, 1'b0, q, ak);
  endtask
  task automatic t_reset();
    `CHK("primary", CTRL_RESET, pri)
    `CHK("secondary", CTRL_RESET, sec)
    `CHK("open drain value", 1'b0, sdo)
  endtask
  task automatic t_write();
    logic a0, a1, a2;
    open_x(BUS_ADDR_LOW, 1'b0, a0);
    i_mcu.xbyte(8'ha5, 1'b0, q, a1);
    i_mcu.xbyte(8'hff, 1'b0, q, a2);
    i_mcu.cond(1'b1);
    `CHK("write acks", 3'h7, {a0, a1, a2})
    `CHK("primary", 8'ha5, pri)
    `CHK("secondary", 8'hff & SECONDARY_MASK, sec)
  endtask
  // third byte is surplus and must be refused
  task automatic t_over();
    logic a0, a1, a2, a3;
    open_x(BUS_ADDR_LOW, 1'b0, a0);
    i_mcu.xbyte(8'h5a, 1'b0, q, a1);
    i_mcu.xbyte(8'h42, 1'b0, q, a2);
    i_mcu.xbyte(8'h33, 1'b0, q, a3);
    i_mcu.cond(1'b1);
    `CHK("over acks", 4'he, {a0, a1, a2, a3})
    `CHK("primary", 8'h5a, pri)
    `CHK("secondary", 8'h00, sec)
  endtask
  // every select code against every address; foreign ones ignored
  task automatic t_addr();
    logic [6:0] am [3] = '{BUS_ADDR_LOW, BUS_ADDR_MID, BUS_ADDR_HIGH};
    logic ak, a2;
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      for (int k = 0; k < 3; k++) begin
        open_x(am[k], 1'b0, ak);
        // foreign writes carry another value, so a landed one would show
        i_mcu.xbyte((s == k) ? 8'h5a : 8'hc3, 1'b0, q, a2);
        i_mcu.cond(1'b1);
        `CHK("address ack", {s == k, s == k}, {ak, a2})
      end
    end
    sel = ADSEL_LOW;
    `CHK("primary", 8'h5a, pri)
  endtask
  // inputs change after the address: bytes keep the snapshot
  task automatic t_read();
    logic [31:0] got;
    logic a0, ak;
    {dg1, dg2, dg3, dg4} = 32'h963ce10f;
    pulses = 0;
    open_x(BUS_ADDR_LOW, 1'b1, a0);
    {dg1, dg2, dg3, dg4} = {4{8'h69}};
    for (int i = 0; i < 4; i++) begin
      i_mcu.xbyte(8'hff, i < 3, q, ak);
      got = {got[23:0], q};
    end
    i_mcu.cond(1'b1);
    i_mcu.wt(4);
    `CHK("read ack", 1'b1, a0)
    `CHK("diag bytes", 32'h963ce10f, got)
    `CHK("restarts", 1, pulses)
  endtask
  // a master refusal ends the device's sending
  task automatic t_nack();
    logic a0, ak;
    pulses = 0;
    open_x(BUS_ADDR_LOW, 1'b1, a0);
    i_mcu.xbyte(8'hff, 1'b0, q, ak);
    `CHK("first byte", 8'h69, q)
    i_mcu.xbyte(8'hff, 1'b0, q, ak);
    `CHK("after refusal", 8'hff, q)
    i_mcu.cond(1'b1);
    i_mcu.wt(4);
    `CHK("restarts", 1, pulses)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    sel = ADSEL_LOW;
    {dg1, dg2, dg3, dg4} = 32'h00000000;
    repeat (10) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    t_reset();
    t_write();
    t_over();
    t_addr();
    t_read();
    t_nack();
    finish_test();
  end
  // hang guard
  initial begin
    #1000000;
    error_cnt++;
    finish_test();
  end
endmodule // amp_i2c_control_status_port_bench
`default_nettype wire
